// File: pkg/irqf_defs.svh
// Summary of operation
// RULE1: 8-bit flag register at 0xC0, resets zero
// RULE2: auto-clear flags cleared when core vectors
// RULE3: bit 7 set on timer2 reload, sticky
// RULE4: bit 6 set on timer2 overflow, sticky
// RULE5: bit 4 usb event, auto-cleared on vector
// RULE6: bit 3 usb wakeup, auto-cleared on vector
// RULE7: bit 2 either spi done, auto-cleared
// RULE8: bit 0 radio link ready, software cleared
// RULE9: spi sources combined, enables at 0xA6
// RULE10: bit 1 radio event, software cleared
`ifndef IRQF_DEFS_SVH
`define IRQF_DEFS_SVH
// ----------------------------------------
// register map (byte addresses, word aligned except the spi enables at 0xA6)
// ----------------------------------------
`define IRQF_ADDR_W            8
`define IRQF_OFS_FLAGS         8'hC0
`define IRQF_OFS_SPI_EN        8'hA6
`define IRQF_OFS_STATUS        8'hD0
`define IRQF_OFS_MASK          8'hD4
`define IRQF_OFS_VECTOR        8'hD8
`define IRQF_RST_FLAGS         8'h00
`define IRQF_RST_SPI_EN        2'h1
`define IRQF_RST_MASK          8'h00
// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define IRQF_BIT_T2_RELOAD     7
`define IRQF_BIT_T2_OVF        6
`define IRQF_BIT_WAKEUP        5
`define IRQF_BIT_USB_EVT       4
`define IRQF_BIT_USB_WAKE      3
`define IRQF_BIT_SPI           2
`define IRQF_BIT_RADIO_EVT     1
`define IRQF_BIT_RADIO_RDY     0
// flags cleared by hardware on vectoring
`define IRQF_AUTO_CLR_MASK     8'h3C
`define IRQF_SPI_EN_MASTER     1
`define IRQF_SPI_EN_SLAVE      0
`endif

// File: pkg/irqf_pkg.sv
package irqf_pkg;
  typedef logic [7:0] irqf_flags_t;
  typedef enum logic [1:0] {IRQF_IDLE, IRQF_WAIT} irqf_bus_e;
endpackage

// File: rtl/irqf_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
module irqf_flag_bit
(
  input  wire logic CLK_IN,
  input  wire logic RST_IN,
  input  wire logic set_in,
  input  wire logic clr_in,
  output var  logic flag_out
);
  // set wins over any clear in the same cycle
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clr_in)
      flag_out <= 1'b0;
  end
endmodule
`default_nettype wire

// File: rtl/irqf_top.sv
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "irqf_defs.svh"
module irqf_top
  import irqf_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic [7:0] AVS_ADDRESS_IN,
  input  wire logic       AVS_READ_IN,
  input  wire logic       AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0]     AVS_READDATA_OUT,
  output logic            AVS_WAITREQUEST_OUT,
  input  wire logic       T2_RELOAD_IN,
  input  wire logic       T2_OVF_IN,
  input  wire logic       WAKEUP_IN,
  input  wire logic       USB_EVT_IN,
  input  wire logic       USB_WAKE_IN,
  input  wire logic       SPI_MASTER_DONE_IN,
  input  wire logic       SPI_SLAVE_DONE_IN,
  input  wire logic       RADIO_EVT_IN,
  input  wire logic       RADIO_RDY_IN,
  input  wire logic       VECTOR_ACK_IN,
  input  wire logic [2:0] VECTOR_BIT_IN,
  output logic [7:0]      FLAGS_OUT,
  output logic            SPI_REQ_OUT,
  output logic            IRQ_OUT
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [8:0] src_meta_q;
  logic [8:0] src_sync_q;
  logic [8:0] src_prev_q;
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      src_meta_q <= 9'h000;
      src_sync_q <= 9'h000;
      src_prev_q <= 9'h000;
    end
    else
    begin
      src_meta_q <= {T2_RELOAD_IN, T2_OVF_IN, WAKEUP_IN, USB_EVT_IN, USB_WAKE_IN,
                     SPI_MASTER_DONE_IN, SPI_SLAVE_DONE_IN, RADIO_EVT_IN, RADIO_RDY_IN};
      src_sync_q <= src_meta_q;
      src_prev_q <= src_sync_q;
    end
  end
  logic [8:0] src_rise;
  logic [8:0] src_fall;
  assign src_rise = src_sync_q & ~src_prev_q;
  assign src_fall = ~src_sync_q & src_prev_q;
  // ----------------------------------------
  // bus slave: one wait cycle per access
  // ----------------------------------------
  irqf_bus_e bus_q;
  logic      acc;
  logic      wr_acc;
  logic      rd_acc;
  assign acc    = (AVS_READ_IN | AVS_WRITE_IN) & (bus_q == IRQF_WAIT);
  assign wr_acc = acc & AVS_WRITE_IN & AVS_BYTEENABLE_IN[0];
  assign rd_acc = acc & AVS_READ_IN;
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      bus_q <= IRQF_IDLE;
    else
    begin
      unique case (bus_q)
        IRQF_IDLE: if (AVS_READ_IN | AVS_WRITE_IN) bus_q <= IRQF_WAIT;
        IRQF_WAIT: bus_q <= IRQF_IDLE;
      endcase
    end
  end
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      AVS_WAITREQUEST_OUT <= 1'b1;
    else
      AVS_WAITREQUEST_OUT <= !((AVS_READ_IN | AVS_WRITE_IN) && bus_q == IRQF_IDLE);
  end
  logic wr_flags;
  logic wr_spi_en;
  logic wr_status;
  logic wr_mask;
  assign wr_flags  = wr_acc && AVS_ADDRESS_IN == `IRQF_OFS_FLAGS;
  assign wr_spi_en = wr_acc && AVS_ADDRESS_IN == `IRQF_OFS_SPI_EN;
  assign wr_status = wr_acc && AVS_ADDRESS_IN == `IRQF_OFS_STATUS;
  assign wr_mask   = wr_acc && AVS_ADDRESS_IN == `IRQF_OFS_MASK;
  // ----------------------------------------
  // spi source enables and combined line
  // ----------------------------------------
  logic [1:0] spi_en_q;
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      spi_en_q <= `IRQF_RST_SPI_EN;
    else if (wr_spi_en)
      spi_en_q <= AVS_WRITEDATA_IN[1:0]; // RULE9
  end
  logic spi_any;
  // either edge of an enabled spi done source counts
  assign spi_any = (spi_en_q[`IRQF_SPI_EN_MASTER] & (src_rise[3] | src_fall[3]))
                 | (spi_en_q[`IRQF_SPI_EN_SLAVE] & (src_rise[2] | src_fall[2])); // RULE9
  // ----------------------------------------
  // flag set and clear terms
  // ----------------------------------------
  irqf_flags_t flag_set;
  irqf_flags_t flag_clr;
  irqf_flags_t flags;
  irqf_flags_t vec_clr;
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[`IRQF_BIT_T2_RELOAD] = src_rise[8]; // RULE3
    flag_set[`IRQF_BIT_T2_OVF]    = src_rise[7]; // RULE4
    flag_set[`IRQF_BIT_WAKEUP]    = src_rise[6];
    flag_set[`IRQF_BIT_USB_EVT]   = src_rise[5]; // RULE5
    flag_set[`IRQF_BIT_USB_WAKE]  = src_rise[4]; // RULE6
    flag_set[`IRQF_BIT_SPI]       = spi_any; // RULE7
    flag_set[`IRQF_BIT_RADIO_EVT] = src_rise[1] | src_fall[1]; // RULE10
    flag_set[`IRQF_BIT_RADIO_RDY] = src_rise[0]; // RULE8
  end
  always_comb
  begin
    vec_clr = 8'h00;
    if (VECTOR_ACK_IN)
      vec_clr[VECTOR_BIT_IN] = 1'b1;
    // only auto-clear flags drop on vectoring
    vec_clr = vec_clr & `IRQF_AUTO_CLR_MASK; // RULE2
  end
  // software writes zero to clear any flag
  assign flag_clr = vec_clr | (wr_flags ? ~AVS_WRITEDATA_IN[7:0] : 8'h00); // RULE3 RULE4 RULE8 RULE10
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      irqf_flag_bit u_bit
      (
        .CLK_IN   (CLK_IN),
        .RST_IN   (RST_IN),
        .set_in   (flag_set[gi]),
        .clr_in   (flag_clr[gi]),
        .flag_out (flags[gi])
      ); // RULE1
    end
  endgenerate
  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  irqf_flags_t status_q;
  irqf_flags_t mask_q;
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      status_q <= 8'h00;
    else
      status_q <= flag_set | (status_q & ~(wr_status ? AVS_WRITEDATA_IN[7:0] : 8'h00));
  end
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      mask_q <= `IRQF_RST_MASK;
    else if (wr_mask)
      mask_q <= AVS_WRITEDATA_IN[7:0];
  end
  // ----------------------------------------
  // outputs and read data
  // ----------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      FLAGS_OUT   <= `IRQF_RST_FLAGS;
      SPI_REQ_OUT <= 1'b0;
      IRQ_OUT     <= 1'b0;
    end
    else
    begin
      FLAGS_OUT   <= flags;
      SPI_REQ_OUT <= flags[`IRQF_BIT_SPI]; // RULE9
      IRQ_OUT     <= |(status_q & mask_q);
    end
  end
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (AVS_ADDRESS_IN)
      `IRQF_OFS_FLAGS:  rd_mux = flags; // RULE1
      `IRQF_OFS_SPI_EN: rd_mux = {6'h00, spi_en_q};
      `IRQF_OFS_STATUS: rd_mux = status_q;
      `IRQF_OFS_MASK:   rd_mux = mask_q;
      default:          rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      AVS_READDATA_OUT <= 32'h0000_0000;
    else if (AVS_READ_IN && bus_q == IRQF_IDLE)
      AVS_READDATA_OUT <= {24'h00_0000, rd_mux};
  end
  // ----------------------------------------
  // bus checks
  // ----------------------------------------
  logic [1:0] wait_low_q;
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      wait_low_q <= 2'h0;
    else if (AVS_WAITREQUEST_OUT)
      wait_low_q <= 2'h0;
    else if (wait_low_q != 2'h3)
      wait_low_q <= wait_low_q + 2'h1;
  end
  AST_WAIT_ANSWER: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (AVS_READ_IN | AVS_WRITE_IN) && bus_q == IRQF_IDLE
    |=> !AVS_WAITREQUEST_OUT)
    else $error("no answer after request");
  AST_WAIT_LOW_ONE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    1'b1
    |-> wait_low_q <= 2'h1)
    else $error("waitrequest low too long");
  AST_RD_ACC: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    rd_acc
    |-> !AVS_WAITREQUEST_OUT)
    else $error("read completed while waiting");
  AST_WR_ACC: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    wr_acc
    |-> !AVS_WAITREQUEST_OUT)
    else $error("write completed while waiting");
  AST_RDATA_UPPER: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    1'b1
    |-> AVS_READDATA_OUT[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  AST_SPI_EN_WRITE: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE9
    wr_spi_en
    |=> spi_en_q == $past(AVS_WRITEDATA_IN[1:0]))
    else $error("spi enable write lost");
  AST_MASK_WRITE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    wr_mask
    |=> mask_q == $past(AVS_WRITEDATA_IN[7:0]))
    else $error("mask write lost");
  // ----------------------------------------
  // status and interrupt checks
  // ----------------------------------------
  AST_STATUS_SET: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    flag_set != 8'h00
    |=> (status_q & $past(flag_set)) == $past(flag_set))
    else $error("status bit not set by event");
  AST_STATUS_W1C: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    wr_status && flag_set == 8'h00
    |=> (status_q & $past(AVS_WRITEDATA_IN[7:0])) == 8'h00)
    else $error("status bit not cleared by write");
  AST_IRQ_HIGH: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (status_q & mask_q) != 8'h00
    |=> IRQ_OUT)
    else $error("interrupt missing");
  AST_IRQ_LOW: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (status_q & mask_q) == 8'h00
    |=> !IRQ_OUT)
    else $error("interrupt without cause");
  // ----------------------------------------
  // flag checks
  // ----------------------------------------
  AST_RESET_ZERO: assert property (@(posedge CLK_IN) // RULE1
    $fell(RST_IN)
    |-> flags == 8'h00)
    else $error("flags not zero after reset");
  AST_FLAGS_COPY: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE1
    1'b1
    |=> FLAGS_OUT == $past(flags))
    else $error("flag output differs from register");
  AST_FLAGS_HOLD: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    flag_set == 8'h00 && flag_clr == 8'h00
    |=> flags == $past(flags))
    else $error("flags changed without cause");
  AST_AUTO_CLR: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE2
    VECTOR_ACK_IN && VECTOR_BIT_IN inside {3'h2, 3'h3, 3'h4, 3'h5} && !flag_set[VECTOR_BIT_IN]
    |=> !flags[$past(VECTOR_BIT_IN)])
    else $error("auto-clear flag survived vectoring");
  AST_WAKEUP: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE2
    src_rise[6]
    |=> flags[5])
    else $error("wakeup flag not set");
  AST_T2_RELOAD: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE3
    src_rise[8]
    |=> flags[7])
    else $error("reload flag not set");
  AST_VEC_KEEP_T2: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE3
    VECTOR_ACK_IN && VECTOR_BIT_IN[2:1] == 2'h3 && !wr_flags
    |=> (flags[7:6] & $past(flags[7:6])) == $past(flags[7:6]))
    else $error("timer flag cleared by vectoring");
  AST_SW_CLEAR: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE3
    wr_flags && flag_set == 8'h00
    |=> (flags & ~$past(AVS_WRITEDATA_IN[7:0])) == 8'h00)
    else $error("software clear lost");
  AST_T2_OVF: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE4
    src_rise[7]
    |=> flags[6])
    else $error("overflow flag not set");
  AST_T2_STICKY: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE4
    flags[7] && flags[6] && !wr_flags
    |=> flags[7] && flags[6])
    else $error("timer flag lost without software clear");
  AST_USB_EVT: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE5
    $rose(src_sync_q[5])
    |=> flags[4])
    else $error("usb flag not set");
  AST_USB_WAKE: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE6
    $rose(src_sync_q[4])
    |=> flags[3])
    else $error("usb wake flag not set");
  AST_SPI: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE7
    spi_any
    |=> flags[2] ##1 SPI_REQ_OUT)
    else $error("spi flag or line missing");
  AST_RDY_SET: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE8
    src_rise[0]
    |=> flags[0])
    else $error("ready flag not set");
  AST_RADIO_RDY: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE8
    flags[0] && !wr_flags
    |=> flags[0])
    else $error("ready flag cleared by hardware");
  AST_VEC_KEEP_RADIO: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE8
    VECTOR_ACK_IN && VECTOR_BIT_IN[2:1] == 2'h0 && !wr_flags
    |=> (flags[1:0] & $past(flags[1:0])) == $past(flags[1:0]))
    else $error("radio flag cleared by vectoring");
  AST_SPI_OFF: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE9
    spi_en_q == 2'h0
    |-> !spi_any)
    else $error("spi event with both sources off");
  AST_SPI_LINE: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE9
    1'b1
    |=> SPI_REQ_OUT == $past(flags[`IRQF_BIT_SPI]))
    else $error("combined spi line differs from flag");
  AST_RADIO_SET: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE10
    src_rise[1] || src_fall[1]
    |=> flags[1])
    else $error("radio flag not set");
  AST_RADIO_EVT: assert property (@(posedge CLK_IN) disable iff (RST_IN) // RULE10
    flags[1] && !wr_flags
    |=> flags[1])
    else $error("radio flag cleared by hardware");
endmodule
`default_nettype wire

// File: test/irqf_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module irqf_core_model
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       go_in,
  input  wire logic [2:0] bit_in,
  input  wire logic [3:0] dly_in,
  output var  logic       ack_out,
  output var  logic [2:0] bit_out
);
  logic [3:0] cnt_q;
  logic       busy_q;
  // ----------------------------------------
  // vectoring: one ack pulse dly_in+1 cycles after go_in is sampled
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      ack_out <= 1'b0;
      bit_out <= 3'h0;
    end
    else if (busy_q && cnt_q == 4'h0)
    begin
      busy_q <= 1'b0;
      ack_out <= 1'b1;
      bit_out <= bit_in;
    end
    else
    begin
      ack_out <= 1'b0;
      bit_out <= ~bit_out;
      if (go_in && !busy_q)
      begin
        busy_q <= 1'b1;
        cnt_q <= dly_in;
      end
      else if (busy_q)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic        waitreq;
  logic [8:0]  ev = 9'h000;
  logic        go = 1'b0;
  logic [2:0]  vbit = 3'h0;
  logic [3:0]  dly = 4'h0;
  logic        ack;
  logic [2:0]  abit;
  logic [7:0]  flags;
  logic        irq;
  logic        spi_req;
  logic [7:0]  q;
  logic [7:0]  expf;
  int          errors = 0;
  int          n_compared = 0;
  always #5 clk = ~clk;
  irqf_top dut (.CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .T2_RELOAD_IN(ev[7]),
    .T2_OVF_IN(ev[6]), .WAKEUP_IN(ev[5]), .USB_EVT_IN(ev[4]), .USB_WAKE_IN(ev[3]),
    .SPI_MASTER_DONE_IN(ev[8]), .SPI_SLAVE_DONE_IN(ev[2]), .RADIO_EVT_IN(ev[1]),
    .RADIO_RDY_IN(ev[0]), .VECTOR_ACK_IN(ack), .VECTOR_BIT_IN(abit), .FLAGS_OUT(flags),
    .SPI_REQ_OUT(spi_req), .IRQ_OUT(irq));
  irqf_core_model core (.clk_in(clk), .rst_in(rst), .go_in(go), .bit_in(vbit),
    .dly_in(dly), .ack_out(ack), .bit_out(abit));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h00_0000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50)
      errors++;
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    repeat (6) @(posedge clk);
    ev[i] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic vec(input logic [2:0] b, input logic [3:0] d);
    @(posedge clk);
    go <= 1'b1;
    vbit <= b;
    dly <= d;
    @(posedge clk);
    go <= 1'b0;
    repeat (24) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    errors++;
    wrap_up();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'hC0, 8'h00); chk(q, 8'h00);
    bus(0, 8'hA6, 8'h00); chk(q, 8'h01);
    bus(1, 8'h10, 8'hFF);
    bus(0, 8'h10, 8'h00); chk(q, 8'h00);
    pulse(8);
    bus(0, 8'hC0, 8'h00); chk(q, 8'h00);
    $display("test reset and spi gate done");
    expf = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      pulse(i);
      expf[i] = 1'b1;
      bus(0, 8'hC0, 8'h00); chk(q, expf);
      chk(flags, expf);
    end
    for (int i = 0; i < 8; i++)
    begin
      vec(i[2:0], (i % 2 == 1) ? 4'h3 : 4'h0);
      if (i >= 2 && i <= 5)
        expf[i] = 1'b0;
      bus(0, 8'hC0, 8'h00); chk(q, expf);
    end
    chk(q, 8'hC3);
    bus(1, 8'hC0, 8'h00);
    bus(0, 8'hC0, 8'h00); chk(q, 8'h00);
    $display("test set and vector done");
    bus(1, 8'hD0, 8'hFF);
    bus(0, 8'hD0, 8'h00); chk(q, 8'h00);
    bus(1, 8'hD4, 8'h01);
    pulse(1);
    chk({7'h00, irq}, 8'h00);
    pulse(0);
    chk({7'h00, irq}, 8'h01);
    bus(1, 8'hD0, 8'h01);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    bus(0, 8'hD4, 8'h00); chk(q, 8'h01);
    $display("test interrupt done");
    bus(1, 8'hA6, 8'h02);
    bus(1, 8'hC0, 8'h00);
    pulse(2);
    bus(0, 8'hC0, 8'h00); chk(q, 8'h00);
    pulse(8);
    bus(0, 8'hC0, 8'h00); chk(q, 8'h04);
    chk({7'h00, spi_req}, 8'h01);
    vec(3'h2, 4'h0);
    bus(0, 8'hC0, 8'h00); chk(q, 8'h00);
    chk({7'h00, spi_req}, 8'h00);
    $display("test spi enables done");
    wrap_up();
  end
endmodule
`default_nettype wire
